/* File: mfm_pkg.sv */
// mfm_pkg: constants and types for the motor driver fault manager
// assumes a single 100 MHz clock; all timing counts derive from it
package mfm_pkg;

  localparam int unsigned CLK_MHZ       = 100;
  // reporting and clearing slack, in ms
  localparam int unsigned REPORT_LAG_MS = 200;
  localparam int unsigned CLEAR_LAG_MS  = 200;
  // retry delays in ms
  localparam int unsigned RETRY_MS      = 1;
  localparam int unsigned STALL_RETRY_MS = 10;
  // divider to a 1 ms tick
  localparam int unsigned MS_CYCLES     = CLK_MHZ * 1000;
  localparam int unsigned MS_CNT_W      = 17;
  localparam int unsigned RETRY_CNT_W   = 16;
  // report lag kept small: one ms tick, well under the allowed lag
  localparam int unsigned REPORT_LAG_TICKS = 1;

  // overcurrent selector codes
  localparam logic [1:0] OC_LATCH  = 2'h0;
  localparam logic [1:0] OC_RETRY  = 2'h1;
  localparam logic [1:0] OC_REPORT = 2'h2;

  // stage output states
  typedef enum logic [1:0] {
    MFM_STAGE_ACTIVE,
    MFM_STAGE_HIZ,
    MFM_STAGE_BRAKE_HI,
    MFM_STAGE_BRAKE_LO
  } mfm_stage_t;

  // fault class
  typedef enum logic [2:0] {
    MFM_CLS_NONE,
    MFM_CLS_REPORT,
    MFM_CLS_RETRY,
    MFM_CLS_LATCH
  } mfm_cls_t;

  // gate-drive flag positions
  localparam int unsigned GD_PUMP = 0;
  localparam int unsigned GD_OV   = 1;
  localparam int unsigned GD_OC   = 2;
  // control flag positions
  localparam int unsigned CF_STALL = 0;
  localparam int unsigned CF_HWLIM = 1;

endpackage

/* File: mfm_stall_decode.sv */
// mfm_stall_decode: maps a 4-bit stall response selector to an action
// assumes purely combinational use inside the fault manager
`timescale 1ns/1ps

module mfm_stall_decode
  import mfm_pkg::*;
(
  input  wire logic [3:0] sel,
  input  wire logic       hw_variant,
  output mfm_cls_t        cls,
  output mfm_stage_t      stage
);

  // decode class and stage response
  always_comb begin
    cls   = MFM_CLS_NONE;
    stage = MFM_STAGE_ACTIVE;
    if (sel[3]) begin
      if (sel == 4'h8) begin
        cls = MFM_CLS_REPORT;
      end
    end else if (hw_variant && sel[2:0] == 3'h1) begin
      cls = MFM_CLS_NONE; // unlisted hard-limit code does nothing
    end else begin
      cls = sel[2] ? MFM_CLS_RETRY : MFM_CLS_LATCH;
      unique case (sel[1:0])
        2'h2:    stage = MFM_STAGE_BRAKE_HI;
        2'h3:    stage = MFM_STAGE_BRAKE_LO;
        default: stage = MFM_STAGE_HIZ;
      endcase
    end
  end

endmodule

/* File: mfm_fault_manager.sv */
// mfm_fault_manager: classifies faults, steers the power stage, reports
// assumes synchronous single-cycle-clean fault levels from analog sensing
`timescale 1ns/1ps

module mfm_fault_manager
  import mfm_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       supply_low_voltage,
  input  wire logic       rail_low_voltage,
  input  wire logic       regulator_overcurrent,
  input  wire logic       pump_low_voltage,
  input  wire logic       supply_overvoltage,
  input  wire logic       phase_overcurrent,
  input  wire logic       stall_fault,
  input  wire logic       hw_stall_current_threshold,
  input  wire logic       overvoltage_guard_on,
  input  wire logic [1:0] overcurrent_response_sel,
  input  wire logic [3:0] stall_response_sel,
  input  wire logic [3:0] hw_stall_limit_response_sel,
  input  wire logic       alarm_output_sel,
  input  wire logic       fault_clear_cmd,
  output mfm_stage_t      stage,
  output logic            core_enable,
  output logic            fault_out_low_pin,
  output logic            alarm_pin,
  output logic [2:0]      gate_fault_flags,
  output logic [1:0]      control_fault_flags
);

  import mfm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // stall decoders

  mfm_cls_t   stall_cls;
  mfm_cls_t   hwlim_cls;
  mfm_stage_t stall_stage;
  mfm_stage_t hwlim_stage;

  mfm_stall_decode u_stall_dec (
    .sel        (stall_response_sel),
    .hw_variant (1'b0),
    .cls        (stall_cls),
    .stage      (stall_stage)
  );

  mfm_stall_decode u_hwlim_dec (
    .sel        (hw_stall_limit_response_sel),
    .hw_variant (1'b1),
    .cls        (hwlim_cls),
    .stage      (hwlim_stage)
  );

  ////////////////////////////////////////////////////////////////////////
  // ms tick divider

  logic [MS_CNT_W-1:0] ms_cnt;
  logic                ms_tick;

  // one-cycle pulse every millisecond
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b0;
    end else if (ms_cnt == MS_CNT_W'(MS_CYCLES - 1)) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + 1'b1;
      ms_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // present fault classification

  logic oc_act;
  logic oc_retry;
  logic oc_latch;
  logic oc_rep;
  logic ov_act;
  logic st_act;
  logic hw_act;
  logic st_latch;
  logic st_retry;
  logic hw_latch;
  logic hw_retry;
  logic core_off;

  // overcurrent and overvoltage qualification
  always_comb begin
    oc_latch = phase_overcurrent && overcurrent_response_sel == OC_LATCH;
    oc_retry = phase_overcurrent && overcurrent_response_sel == OC_RETRY;
    oc_rep   = phase_overcurrent && overcurrent_response_sel == OC_REPORT;
    oc_act   = oc_latch || oc_retry;
    ov_act   = supply_overvoltage && overvoltage_guard_on;
    st_act   = stall_fault && stall_cls != MFM_CLS_NONE;
    hw_act   = hw_stall_current_threshold && hwlim_cls != MFM_CLS_NONE;
    st_latch = st_act && stall_cls == MFM_CLS_LATCH;
    st_retry = st_act && stall_cls == MFM_CLS_RETRY;
    hw_latch = hw_act && hwlim_cls == MFM_CLS_LATCH;
    hw_retry = hw_act && hwlim_cls == MFM_CLS_RETRY;
    core_off = supply_low_voltage || rail_low_voltage
               || regulator_overcurrent;
  end

  ////////////////////////////////////////////////////////////////////////
  // latched fault state

  logic       latch_oc;
  logic       latch_st;
  logic       latch_hw;
  mfm_stage_t latch_stage;
  logic       any_latch;

  assign any_latch = latch_oc || latch_st || latch_hw;

  // latched faults hold until clear; a new event beats the clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      latch_oc    <= 1'b0;
      latch_st    <= 1'b0;
      latch_hw    <= 1'b0;
      latch_stage <= MFM_STAGE_ACTIVE;
    end else if (!core_off) begin
      latch_oc <= oc_latch || (latch_oc && !fault_clear_cmd);
      latch_st <= st_latch || (latch_st && !fault_clear_cmd);
      latch_hw <= hw_latch || (latch_hw && !fault_clear_cmd);
      if (oc_latch) begin
        latch_stage <= MFM_STAGE_HIZ;
      end else if (st_latch && !any_latch) begin
        latch_stage <= stall_stage;
      end else if (hw_latch && !any_latch) begin
        latch_stage <= hwlim_stage;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // retry timers

  logic [RETRY_CNT_W-1:0] short_cnt;
  logic [RETRY_CNT_W-1:0] long_cnt;
  logic                   short_live;
  logic                   long_live;
  logic                   long_st;
  logic                   long_hw;
  mfm_stage_t             long_stage;

  // short retry: overcurrent restarts while present, counts after
  // one tick extra: the tick phase is free, so the hold never falls short
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      short_cnt <= '0;
    end else if (oc_retry) begin
      short_cnt <= RETRY_CNT_W'(RETRY_MS + 1);
    end else if (ms_tick && short_cnt != '0) begin
      short_cnt <= short_cnt - 1'b1;
    end
  end

  // long retry: stall faults with retry class
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      long_cnt   <= '0;
      long_stage <= MFM_STAGE_HIZ;
    end else if (st_retry || hw_retry) begin
      long_cnt   <= RETRY_CNT_W'(STALL_RETRY_MS + 1);
      long_stage <= st_retry ? stall_stage : hwlim_stage;
    end else if (ms_tick && long_cnt != '0) begin
      long_cnt <= long_cnt - 1'b1;
    end
  end

  assign short_live = short_cnt != '0;
  assign long_live  = long_cnt != '0;

  // remember which stall source runs the long retry, for its status flag
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      long_st <= 1'b0;
      long_hw <= 1'b0;
    end else begin
      long_st <= st_retry || (long_st && long_live);
      long_hw <= hw_retry || (long_hw && long_live);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stage response by priority

  mfm_stage_t next_stage;

  // core off, then latched, then long retry, then short retry, then auto faults
  always_comb begin
    if (core_off) begin
      next_stage = MFM_STAGE_HIZ;
    end else if (any_latch) begin
      next_stage = latch_stage;
    end else if (long_live) begin
      next_stage = long_stage;
    end else if (short_live || pump_low_voltage || ov_act) begin
      next_stage = MFM_STAGE_HIZ;
    end else begin
      next_stage = MFM_STAGE_ACTIVE;
    end
  end

  // registered stage and core enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stage       <= MFM_STAGE_HIZ;
      core_enable <= 1'b0;
    end else begin
      stage       <= next_stage;
      core_enable <= !core_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags

  // gate-drive flags: sticky for latched, follow for auto faults
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gate_fault_flags <= '0;
    end else if (core_off) begin
      gate_fault_flags <= '0;
    end else begin
      gate_fault_flags[GD_PUMP] <= pump_low_voltage;
      gate_fault_flags[GD_OV]   <= ov_act;
      gate_fault_flags[GD_OC]   <= oc_act || oc_rep || latch_oc
                                   || short_live;
    end
  end

  // controller flags for stall faults
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      control_fault_flags <= '0;
    end else if (core_off) begin
      control_fault_flags <= '0;
    end else begin
      control_fault_flags[CF_STALL] <= st_act || latch_st
                                       || (long_live && long_st);
      control_fault_flags[CF_HWLIM] <= hw_act || latch_hw
                                       || (long_live && long_hw);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins

  logic actionable;
  logic report_only;

  // classify what is pending for the pins
  always_comb begin
    actionable  = any_latch || long_live || short_live || oc_act
                  || pump_low_voltage || ov_act
                  || (st_act && stall_cls != MFM_CLS_REPORT)
                  || (hw_act && hwlim_cls != MFM_CLS_REPORT);
    report_only = oc_rep || (st_act && stall_cls == MFM_CLS_REPORT)
                  || (hw_act && hwlim_cls == MFM_CLS_REPORT);
  end

  // pins register on the same edge as the stage, well inside the lag bound
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_out_low_pin <= 1'b1;
      alarm_pin         <= 1'b0;
    end else if (core_off) begin
      fault_out_low_pin <= 1'b1;
      alarm_pin         <= 1'b0;
    end else begin
      fault_out_low_pin <= !(actionable
                             || (report_only && !alarm_output_sel));
      alarm_pin <= alarm_output_sel
                   && (actionable || report_only);
    end
  end

endmodule

/* File: mfm_fault_manager_properties.sv */
// mfm_fault_manager_properties: timing checks on the fault manager ports
// assumes one ref_clk domain and the registered outputs of the note
`timescale 1ns/1ps

module mfm_fault_manager_properties
  import mfm_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       supply_low_voltage,
  input wire logic       rail_low_voltage,
  input wire logic       regulator_overcurrent,
  input wire logic       pump_low_voltage,
  input wire logic       supply_overvoltage,
  input wire logic       phase_overcurrent,
  input wire logic       stall_fault,
  input wire logic       hw_stall_current_threshold,
  input wire logic       overvoltage_guard_on,
  input wire logic [1:0] overcurrent_response_sel,
  input wire logic       alarm_output_sel,
  input wire mfm_stage_t stage,
  input wire logic       core_enable,
  input wire logic       fault_out_low_pin,
  input wire logic       alarm_pin,
  input wire logic [2:0] gate_fault_flags,
  input wire logic [1:0] control_fault_flags
);
  logic ok;
  logic calm;
  logic ovf;
  // core alive, and only an overcurrent report is pending
  assign ok = !(supply_low_voltage || rail_low_voltage
              || regulator_overcurrent);
  assign ovf = overvoltage_guard_on && supply_overvoltage;
  assign calm = ok && !pump_low_voltage && !ovf && !stall_fault
              && !hw_stall_current_threshold && phase_overcurrent
              && overcurrent_response_sel == OC_REPORT;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  core_off_a: assert property (!ok |=>
    !core_enable && stage == MFM_STAGE_HIZ) else $error("core stays on");
  core_silent_a: assert property (!ok |=>
    gate_fault_flags == 3'h0 && control_fault_flags == 2'h0)
    else $error("core off fault reported");
  pump_stage_a: assert property (ok && pump_low_voltage |=>
    stage != MFM_STAGE_ACTIVE && core_enable) else $error("pump no hiz");
  pump_pin_a: assert property (ok && pump_low_voltage |->
    ##[1:3] !fault_out_low_pin) else $error("pump pin not low");
  ov_off_a: assert property (
    !overvoltage_guard_on && supply_overvoltage
    |=> !gate_fault_flags[GD_OV]) else $error("ov seen");
  ov_on_a: assert property (ok && ovf |=>
    gate_fault_flags[GD_OV] && stage != MFM_STAGE_ACTIVE)
    else $error("ov not acted on");
  ov_alarm_a: assert property (ok && ovf && alarm_output_sel |->
    ##[1:3] alarm_pin) else $error("alarm not raised");
  report_stay_a: assert property (calm && stage == MFM_STAGE_ACTIVE
    |=> stage == MFM_STAGE_ACTIVE) else $error("report only acted");
  report_pin_a: assert property (calm && alarm_output_sel &&
    stage == MFM_STAGE_ACTIVE |=> fault_out_low_pin)
    else $error("report pulled pin");
  cover property (stage == MFM_STAGE_BRAKE_HI);
  cover property (stage == MFM_STAGE_BRAKE_LO);
  cover property (!core_enable);
endmodule

bind mfm_fault_manager mfm_fault_manager_properties
  mfm_fault_manager_properties_i (.ref_clk, .rstn, .supply_low_voltage,
  .rail_low_voltage, .regulator_overcurrent, .pump_low_voltage,
  .supply_overvoltage, .phase_overcurrent, .stall_fault,
  .hw_stall_current_threshold, .overvoltage_guard_on,
  .overcurrent_response_sel, .alarm_output_sel, .stage, .core_enable,
  .fault_out_low_pin, .alarm_pin, .gate_fault_flags,
  .control_fault_flags);

/* File: mfm_host_model.sv */
// mfm_host_model: host side that writes the fault clear bit
// assumes the bench asks for a clear by raising clear_req one cycle
`timescale 1ns/1ps

module mfm_host_model (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic clear_req,
  output logic      fault_clear_cmd
);
  // one write of 1 to the clear bit per request
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) fault_clear_cmd <= 1'b0;
    else fault_clear_cmd <= clear_req;
  end
endmodule

/* File: test_motor_driver_fault_manager.sv */
// test_motor_driver_fault_manager: directed bench for the fault manager
// assumes inputs change 1 ns after ref_clk rises
`timescale 1ns/1ps

module test_motor_driver_fault_manager;
  import mfm_pkg::*;
  logic ref_clk = 0, rstn = 0, clear_req = 0;
  logic supply_low_voltage = 0, rail_low_voltage = 0;
  logic regulator_overcurrent = 0, pump_low_voltage = 0;
  logic supply_overvoltage = 0, phase_overcurrent = 0;
  logic stall_fault = 0, hw_stall_current_threshold = 0;
  logic overvoltage_guard_on = 0, alarm_output_sel = 0;
  logic [1:0] overcurrent_response_sel = 2'h3;
  logic [3:0] stall_response_sel = 4'hf;
  logic [3:0] hw_stall_limit_response_sel = 4'hf;
  logic fault_clear_cmd, core_enable, fault_out_low_pin, alarm_pin;
  mfm_stage_t stage;
  logic [2:0] gate_fault_flags;
  logic [1:0] control_fault_flags;
  int n_errors = 0, checked = 0;
  logic [3:0] cd [5] = '{4'h0, 4'h2, 4'h3, 4'h8, 4'h9};
  logic [1:0] st [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};

  mfm_host_model mfm_host_model_i (.ref_clk, .rstn, .clear_req,
    .fault_clear_cmd);
  mfm_fault_manager mfm_fault_manager_i (.ref_clk, .rstn,
    .supply_low_voltage, .rail_low_voltage, .regulator_overcurrent,
    .pump_low_voltage, .supply_overvoltage, .phase_overcurrent,
    .stall_fault, .hw_stall_current_threshold, .overvoltage_guard_on,
    .overcurrent_response_sel, .stall_response_sel,
    .hw_stall_limit_response_sel, .alarm_output_sel, .fault_clear_cmd,
    .stage, .core_enable, .fault_out_low_pin, .alarm_pin,
    .gate_fault_flags, .control_fault_flags);

  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // all outputs packed as stage, core, pin, alarm, gate, control
  task automatic chk(input logic [9:0] x);
    logic [9:0] g;
    g = {stage, core_enable, fault_out_low_pin, alarm_pin,
         gate_fault_flags, control_fault_flags};
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  function automatic logic [9:0] e(logic [1:0] s, int p, int a,
                                   logic [2:0] g, logic [1:0] c);
    return {s, 1'b1, p[0], a[0], g, c};
  endfunction
  task automatic clr();
    clear_req = 1;
    cyc(1);
    clear_req = 0;
    cyc(5);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_auto();
    pump_low_voltage = 1;
    cyc(5);
    chk(e(2'h1, 0, 0, 3'h1, 2'h0));
    pump_low_voltage = 0;
    supply_overvoltage = 1;
    cyc(5);
    chk(e(2'h0, 1, 0, 3'h0, 2'h0));
    overvoltage_guard_on = 1;
    alarm_output_sel = 1;
    cyc(5);
    chk(e(2'h1, 0, 1, 3'h2, 2'h0));
    supply_overvoltage = 0;
    cyc(5);
    chk(e(2'h0, 1, 0, 3'h0, 2'h0));
  endtask
  // each core-off source, with a pump fault that must stay silent
  task automatic t_core();
    pump_low_voltage = 1;
    for (int i = 0; i < 3; i++) begin
      {supply_low_voltage, rail_low_voltage, regulator_overcurrent}
        = 3'h1 << i;
      cyc(5);
      chk(10'h140);
    end
    {supply_low_voltage, rail_low_voltage, regulator_overcurrent} = 0;
    pump_low_voltage = 0;
    cyc(5);
    chk(e(2'h0, 1, 0, 3'h0, 2'h0));
  endtask
  task automatic t_stall();
    alarm_output_sel = 0;
    for (int j = 0; j < 2; j++)
      for (int k = 0; k < 5; k++) begin
        stall_response_sel = cd[k];
        hw_stall_limit_response_sel = cd[k];
        if (j == 1) hw_stall_current_threshold = 1;
        else stall_fault = 1;
        cyc(5);
        chk(e(st[k], k == 4, 0, 3'h0,
              k == 4 ? 2'h0 : 2'(j + 1)));
        stall_fault = 0;
        hw_stall_current_threshold = 0;
        clr();
        chk(e(2'h0, 1, 0, 3'h0, 2'h0));
      end
  endtask
  task automatic t_report();
    alarm_output_sel = 1;
    overcurrent_response_sel = OC_REPORT;
    phase_overcurrent = 1;
    cyc(5);
    chk(e(2'h0, 1, 1, 3'h4, 2'h0));
    overcurrent_response_sel = 2'h3;
    cyc(5);
    chk(e(2'h0, 1, 0, 3'h0, 2'h0));
    phase_overcurrent = 0;
    alarm_output_sel = 0;
  endtask
  // latched overcurrent, then latched plus retry, then a retry brake
  task automatic t_latch();
    overcurrent_response_sel = OC_LATCH;
    phase_overcurrent = 1;
    cyc(5);
    chk(e(2'h1, 0, 0, 3'h4, 2'h0));
    phase_overcurrent = 0;
    cyc(50);
    chk(e(2'h1, 0, 0, 3'h4, 2'h0));
    clr();
    chk(e(2'h0, 1, 0, 3'h0, 2'h0));
    stall_response_sel = 4'h4;
    phase_overcurrent = 1;
    stall_fault = 1;
    cyc(5);
    chk(e(2'h1, 0, 0, 3'h4, 2'h1));
    stall_fault = 0;
    clr();
    chk(e(2'h1, 0, 0, 3'h4, 2'h1));
    phase_overcurrent = 0;
    stall_response_sel = 4'h7;
    rstn = 0;
    cyc(4);
    chk(10'h140);
    rstn = 1;
    stall_fault = 1;
    cyc(5);
    chk(e(2'h3, 0, 0, 3'h0, 2'h1));
    stall_fault = 0;
    cyc(50);
    chk(e(2'h3, 0, 0, 3'h0, 2'h1));
  endtask
  // short retry under a long one, alone, then a hard-limit retry brake
  task automatic t_retry();
    overcurrent_response_sel = OC_RETRY;
    phase_overcurrent = 1;
    cyc(5);
    chk(e(2'h3, 0, 0, 3'h4, 2'h1));
    phase_overcurrent = 0;
    cyc(20);
    chk(e(2'h3, 0, 0, 3'h4, 2'h1));
    rstn = 0;
    cyc(2);
    rstn = 1;
    phase_overcurrent = 1;
    cyc(5);
    chk(e(2'h1, 0, 0, 3'h4, 2'h0));
    phase_overcurrent = 0;
    cyc(20);
    chk(e(2'h1, 0, 0, 3'h4, 2'h0));
    hw_stall_limit_response_sel = 4'h7;
    hw_stall_current_threshold = 1;
    cyc(5);
    chk(e(2'h3, 0, 0, 3'h4, 2'h2));
    hw_stall_current_threshold = 0;
    overcurrent_response_sel = 2'h3;
  endtask
  task automatic test_done();
    $display("errors=%0d checked=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    cyc(4);
    rstn = 1;
    cyc(1);
    t_auto();
    t_core();
    t_stall();
    t_report();
    t_latch();
    t_retry();
    test_done();
  end
endmodule
